// *** core/mapper_pkg.sv ***
// shared constants, offsets, codes and tables for the data area mapper
package mapper_pkg;
  // component kinds
  typedef enum logic {
    comp_temp = 1'b0, // temperature controller
    comp_meter = 1'b1 // panel meter
  } comp_kind_t;

  // offsets inside every area
  localparam logic [4:0] OFF_MONITOR = 5'h00; // response monitor word
  localparam logic [3:0] TC_OFF_TARGET = 4'h1; // target temperature
  localparam logic [3:0] TC_OFF_OPCMD = 4'h2; // controller operation word
  localparam logic [3:0] PM_OFF_OPCMD = 4'h1; // meter operation word
  localparam logic [3:0] PM_OFF_PAIR = 4'h2; // first comparison pair
  localparam logic [3:0] FIRST_DATA = 4'h1; // first data offset
  localparam logic [3:0] TC_WRITE_WORDS = 4'h9; // controller write area size
  localparam logic [4:0] PM_WRITE_WORDS = 5'h0a; // meter write area size
  localparam logic [2:0] PM_SEL_STATUS_LIMIT = 3'h3; // sels below own status

  // operation codes
  localparam logic [15:0] OP_NONE = 16'h0000; // no operation
  localparam logic [15:0] TC_OP_AUTOTUNE_START = 16'h0002; // blocks setpoints
  localparam logic [15:0] TC_OP_MAX = 16'h0005; // highest controller code
  localparam logic [15:0] PM_OP_MAX = 16'h0004; // highest meter code

  // low word offset of a meter read value, by selector
  function automatic logic [4:0] read_low_off(input logic [2:0] sel);
    unique case (sel)
      3'h0: read_low_off = 5'h01; // display value
      3'h1: read_low_off = 5'h04; // peak hold
      3'h2: read_low_off = 5'h07; // bottom hold
      3'h3: read_low_off = 5'h0a; // upper_upper_limit comparison
      3'h4: read_low_off = 5'h0c; // upper comparison
      3'h5: read_low_off = 5'h0e; // lower comparison
      3'h6: read_low_off = 5'h10; // lower_lower_limit comparison
      default: read_low_off = 5'h01; // unused selector code
    endcase
  endfunction

  // words of a write area sent under each command group, bit = offset
  function automatic logic [9:0] write_mask(input comp_kind_t kind,
                                            input logic [2:0] grp);
    write_mask = 10'h000;
    if (kind == comp_temp) begin
      unique case (grp)
        3'h1: write_mask = 10'h006; // target, operation
        3'h2: write_mask = 10'h01e; // target, operation, alarms
        3'h3: write_mask = 10'h0e6; // target, operation, pid
        3'h4: write_mask = 10'h11a; // target, alarms, heater value
        3'h5: write_mask = 10'h0fe; // target, operation, alarms, pid
        default: write_mask = 10'h000; // no group, nothing sent
      endcase
    end else begin
      unique case (grp)
        3'h3: write_mask = 10'h002; // operation only
        3'h4: write_mask = 10'h3fc; // four comparison pairs
        3'h5: write_mask = 10'h3fe; // operation and pairs
        default: write_mask = 10'h000; // groups 1, 2: nothing
      endcase
    end
  endfunction
endpackage

// *** core/dm_word_port.sv ***
// single outstanding word access to the controller data memory
module dm_word_port #(
  parameter int AW = 16, // word address width
  parameter int DW = 16  // word width
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic req, // access request, level
  input wire logic we, // 1 write, 0 read
  input wire logic [AW-1:0] addr, // word address
  input wire logic [DW-1:0] wdata, // write word
  output logic busy, // access in flight
  output logic done, // one-cycle completion pulse
  output logic [DW-1:0] rdata, // read word, registered
  output logic dm_req, // memory request, held to ack
  output logic dm_we, // memory write enable
  output logic [AW-1:0] dm_addr, // memory word address
  output logic [DW-1:0] dm_wdata, // memory write word
  input wire logic dm_ack, // memory acknowledge pulse
  input wire logic [DW-1:0] dm_rdata // memory read word at ack
);
  // launch on request, retire on acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      dm_req <= 1'b0;
      dm_we <= 1'b0;
      dm_addr <= '0;
      dm_wdata <= '0;
    end else if (!busy && req) begin
      busy <= 1'b1; // hold the bus until ack
      dm_req <= 1'b1;
      dm_we <= we;
      dm_addr <= addr;
      dm_wdata <= wdata;
    end else if (busy && dm_ack) begin
      busy <= 1'b0;
      dm_req <= 1'b0;
    end
  end

  // completion pulse and captured read word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= busy && dm_ack;
      if (busy && dm_ack) begin
        rdata <= dm_rdata; // kept for reads and writes alike
      end
    end
  end
endmodule

// *** core/component_data_area_mapper.sv ***
// maps data memory areas to and from serially attached components
// How it works
// - meter read value low then high word
// - read error zeroes value and status words
// - meter status words at plus three, six, nine
// - response monitor word sits at offset zero
// - controller write area spans nine words
// - target temperature sent under every group
// - write error stops, records code, moves on
// - controller operation codes zero to five
// - operation sent only if group includes it
// - start auto-tuning scan sends no setpoints
// - meter write area spans ten words
// - comparison pairs only in groups four, five
// - meter write value low even, high odd
// - meter operation codes zero to four
module component_data_area_mapper #(
  parameter int AW = 16, // data memory word address width
  parameter int DW = 16  // data memory word width
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic wr_start, // pulse: start a write area pass
  input wire logic [AW-1:0] wr_base, // write area start address
  input wire logic [AW-1:0] rd_base, // read area start address
  input wire mapper_pkg::comp_kind_t kind, // component kind
  input wire logic [2:0] grp, // command group 1 to 5
  output logic busy, // a pass is running
  output logic wr_done, // pulse: write pass finished
  output logic dm_req, // memory request
  output logic dm_we, // memory write enable
  output logic [AW-1:0] dm_addr, // memory word address
  output logic [DW-1:0] dm_wdata, // memory write word
  input wire logic dm_ack, // memory acknowledge
  input wire logic [DW-1:0] dm_rdata, // memory read word
  output logic tx_valid, // value ready for the component
  input wire logic tx_ready, // link takes the value
  output logic [3:0] tx_offset, // write area offset of the value
  output logic [31:0] tx_data, // value, signed
  input wire logic tx_ack, // link reply pulse
  input wire logic tx_err, // reply carries an error
  input wire logic [15:0] tx_code, // error code with the reply
  input wire logic rx_valid, // meter value arrived
  output logic rx_ready, // value taken
  input wire logic [2:0] rx_sel, // which meter value
  input wire logic [31:0] rx_value, // value read, signed
  input wire logic [15:0] rx_status, // status of the value
  input wire logic rx_err, // read failed
  input wire logic [15:0] rx_code // error code of the read
);
  // gray codes along the write path, then the read path
  typedef enum logic [3:0] {
    s_idle = 4'h0, s_w_op = 4'h1, s_w_scan = 4'h3, s_w_lo = 4'h2,
    s_w_hi = 4'h6, s_w_send = 4'h7, s_w_wait = 4'h5, s_w_mon = 4'h4,
    s_r_lo = 4'hc, s_r_hi = 4'hd, s_r_st = 4'hf, s_r_mon = 4'he
  } state_t;

  state_t state; // sequencer state
  mapper_pkg::comp_kind_t cur_kind; // kind latched at start
  logic [AW-1:0] base; // area start latched at start
  logic [9:0] mask; // words the group sends
  logic [3:0] idx; // next offset to examine
  logic [3:0] cur; // offset being handled
  logic skip_sv; // auto-tuning start seen
  logic [15:0] code; // response monitor value
  logic [2:0] r_sel; // latched read selector
  logic [31:0] r_val; // latched read value
  logic [15:0] r_st; // latched read status
  logic r_err; // latched read error
  logic mem_req; // access wanted this cycle
  logic mem_we; // access is a write
  logic [4:0] mem_off; // offset in the area
  logic [DW-1:0] mem_wdata; // word to write
  logic port_busy; // access in flight
  logic port_done; // access finished
  logic [DW-1:0] port_rdata; // word read
  logic [3:0] op_off; // operation word offset
  logic [3:0] hit; // next offset to send, 0 none
  logic is_pair; // current offset holds a pair
  logic [9:0] start_mask; // words the requested group sends
  logic [15:0] rx_code_q; // latched read error code

  // lowest masked offset not below from, zero when none
  function automatic logic [3:0] next_index(input logic [9:0] m,
                                            input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 9; i >= 1; i--) begin
      if (m[i] && 4'(i) >= from) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // operation code within the accepted range and not a no-op
  function automatic logic op_ok(input mapper_pkg::comp_kind_t k,
                                 input logic [15:0] w);
    logic [15:0] lim;
    lim = (k == mapper_pkg::comp_temp) ? mapper_pkg::TC_OP_MAX
                                       : mapper_pkg::PM_OP_MAX;
    return (w != mapper_pkg::OP_NONE) && (w <= lim);
  endfunction

  // operation offset and pair test for the latched kind
  always_comb begin
    start_mask = mapper_pkg::write_mask(kind, grp);
    op_off = (cur_kind == mapper_pkg::comp_temp) ? mapper_pkg::TC_OFF_OPCMD
                                                 : mapper_pkg::PM_OFF_OPCMD;
    is_pair = (cur_kind == mapper_pkg::comp_meter)
              && (cur >= mapper_pkg::PM_OFF_PAIR);
    // with auto-tuning start only the operation word may go out
    hit = next_index(skip_sv ? (mask & (10'h001 << op_off)) : mask,
                     idx);
  end

  // memory access wanted by each state
  always_comb begin
    mem_we = 1'b1;
    mem_off = mapper_pkg::OFF_MONITOR;
    mem_wdata = code;
    unique case (state)
      s_w_op: begin
        mem_we = 1'b0;
        mem_off = {1'b0, mapper_pkg::TC_OFF_OPCMD};
      end
      s_w_lo: begin
        mem_we = 1'b0;
        mem_off = {1'b0, cur};
      end
      s_w_hi: begin
        mem_we = 1'b0;
        mem_off = {1'b0, cur} + 5'h01;
      end
      s_r_lo: begin
        mem_off = mapper_pkg::read_low_off(r_sel);
        mem_wdata = r_err ? '0 : r_val[15:0];
      end
      s_r_hi: begin
        mem_off = mapper_pkg::read_low_off(r_sel) + 5'h01;
        mem_wdata = r_err ? '0 : r_val[31:16];
      end
      s_r_st: begin
        // display, peak and bottom status at +3, +6, +9
        mem_off = mapper_pkg::read_low_off(r_sel) + 5'h02;
        mem_wdata = r_err ? '0 : r_st;
      end
      s_r_mon: begin
        mem_wdata = r_err ? rx_code_q : '0;
      end
      default: begin
        mem_we = 1'b1; // write monitor or no access
      end
    endcase
    mem_req = (state inside {s_w_op, s_w_lo, s_w_hi, s_w_mon,
                             s_r_lo, s_r_hi, s_r_st, s_r_mon})
              && !port_busy && !port_done;
  end

  dm_word_port #(.AW(AW), .DW(DW)) u_port (
    .clk(clk),
    .rst_n(rst_n),
    .req(mem_req),
    .we(mem_we),
    .addr(base + AW'(mem_off)),
    .wdata(mem_wdata),
    .busy(port_busy),
    .done(port_done),
    .rdata(port_rdata),
    .dm_req(dm_req),
    .dm_we(dm_we),
    .dm_addr(dm_addr),
    .dm_wdata(dm_wdata),
    .dm_ack(dm_ack),
    .dm_rdata(dm_rdata)
  );

  // handshakes
  assign busy = (state != s_idle);
  assign tx_valid = (state == s_w_send);
  assign rx_ready = (state == s_idle) && !wr_start; // writes first

  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= s_idle;
    end else begin
      unique case (state)
        s_idle: begin
          if (wr_start) begin
            state <= (kind == mapper_pkg::comp_temp
                      && start_mask[mapper_pkg::TC_OFF_OPCMD])
                     ? s_w_op : s_w_scan; // op looked at first
          end else if (rx_valid) begin
            state <= s_r_lo;
          end
        end
        s_w_op: if (port_done) state <= s_w_scan;
        s_w_scan: state <= (hit == 4'h0) ? s_w_mon : s_w_lo;
        s_w_lo: begin
          if (port_done) begin
            if (is_pair) begin
              state <= s_w_hi;
            end else if (cur == op_off && !op_ok(cur_kind, port_rdata)) begin
              state <= s_w_scan;
            end else begin
              state <= s_w_send;
            end
          end
        end
        s_w_hi: if (port_done) state <= s_w_send;
        s_w_send: if (tx_ready) state <= s_w_wait;
        s_w_wait: begin
          if (tx_ack) begin
            state <= tx_err ? s_w_mon : s_w_scan;
          end
        end
        s_w_mon: if (port_done) state <= s_idle;
        s_r_lo: if (port_done) state <= s_r_hi;
        s_r_hi: begin
          if (port_done) begin
            state <= (r_sel < mapper_pkg::PM_SEL_STATUS_LIMIT)
                     ? s_r_st : s_r_mon;
          end
        end
        s_r_st: if (port_done) state <= s_r_mon;
        s_r_mon: if (port_done) state <= s_idle;
        default: state <= s_idle;
      endcase
    end
  end

  // pass context latched at start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_kind <= mapper_pkg::comp_temp;
      base <= '0;
      mask <= '0;
    end else if (state == s_idle && wr_start) begin
      cur_kind <= kind;
      base <= wr_base;
      mask <= mapper_pkg::write_mask(kind, grp);
    end else if (state == s_idle && rx_valid) begin
      cur_kind <= mapper_pkg::comp_meter;
      base <= rd_base;
    end
  end

  // walk position, auto-tuning guard and monitor code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= mapper_pkg::FIRST_DATA;
      cur <= '0;
      skip_sv <= 1'b0;
      code <= '0;
    end else if (state == s_idle) begin
      idx <= mapper_pkg::FIRST_DATA;
      skip_sv <= 1'b0;
      code <= '0;
    end else if (state == s_w_op && port_done) begin
      skip_sv <= (port_rdata == mapper_pkg::TC_OP_AUTOTUNE_START);
    end else if (state == s_w_scan) begin
      cur <= hit;
    end else if (state == s_w_lo && port_done) begin
      idx <= cur + (is_pair ? 4'h2 : 4'h1);
    end else if (state == s_w_wait && tx_ack && tx_err) begin
      code <= tx_code;
    end
  end

  // value to the link, low word then high word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_offset <= '0;
      tx_data <= '0;
    end else if (state == s_w_lo && port_done) begin
      tx_offset <= cur;
      tx_data <= {{16{port_rdata[15]}}, port_rdata}; // sign extend
    end else if (state == s_w_hi && port_done) begin
      tx_data[31:16] <= port_rdata;
    end
  end

  // meter read value latched on acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_sel <= '0;
      r_val <= '0;
      r_st <= '0;
      r_err <= 1'b0;
      rx_code_q <= '0;
    end else if (rx_valid && rx_ready) begin
      r_sel <= rx_sel;
      r_val <= rx_value;
      r_st <= rx_status;
      r_err <= rx_err;
      rx_code_q <= rx_code;
    end
  end

  // completion pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= (state == s_w_mon) && port_done;
    end
  end

  // checks
  sequence s_fail;
    state == s_w_wait && tx_ack && tx_err;
  endsequence
  property p_fail_mon;
    @(posedge clk) disable iff (!rst_n)
    s_fail |=> (state == s_w_mon && mem_wdata == $past(tx_code)
                && mem_off == mapper_pkg::OFF_MONITOR);
  endproperty
  a_fail_mon: assert property (p_fail_mon) else $error("no code");
  property p_zero;
    @(posedge clk) disable iff (!rst_n)
    (mem_req && r_err && state inside {s_r_lo, s_r_hi, s_r_st})
    |-> mem_wdata == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("bad error fill");
  property p_low_off;
    @(posedge clk) disable iff (!rst_n)
    (state == s_r_lo && r_sel == 3'h3) |-> mem_off == 5'h0a;
  endproperty
  a_low_off: assert property (p_low_off) else $error("bad low");
  property p_status;
    @(posedge clk) disable iff (!rst_n)
    (state == s_r_st) |-> mem_off inside {5'h03, 5'h06, 5'h09};
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_tc_span;
    @(posedge clk) disable iff (!rst_n)
    (mem_req && cur_kind == mapper_pkg::comp_temp && state != s_r_lo)
    |-> mem_off < 5'(mapper_pkg::TC_WRITE_WORDS);
  endproperty
  a_tc_span: assert property (p_tc_span) else $error("tc span");
  property p_pm_span;
    @(posedge clk) disable iff (!rst_n)
    (mem_req && state inside {s_w_lo, s_w_hi})
    |-> mem_off < mapper_pkg::PM_WRITE_WORDS;
  endproperty
  a_pm_span: assert property (p_pm_span) else $error("pm span");
  property p_autotune;
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && skip_sv) |-> tx_offset == mapper_pkg::TC_OFF_OPCMD;
  endproperty
  a_autotune: assert property (p_autotune) else $error("sv sent");
  property p_op_range;
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && tx_offset == op_off) |-> op_ok(cur_kind, tx_data[15:0]);
  endproperty
  a_op_range: assert property (p_op_range) else $error("bad op");
  property p_pairs;
    @(posedge clk) disable iff (!rst_n)
    (tx_valid && cur_kind == mapper_pkg::comp_meter
     && tx_offset >= mapper_pkg::PM_OFF_PAIR) |-> mask[9:2] == 8'hff;
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair sent");
  property p_ascend;
    @(posedge clk) disable iff (!rst_n)
    (state == s_w_scan && hit != 4'h0) |-> hit >= idx ##1 cur >= $past(idx);
  endproperty
  a_ascend: assert property (p_ascend) else $error("out of order");
endmodule

// *** test/link_model.sv ***
// link side model: takes values, replies after a stall, fails on demand
module link_model (
  input wire logic clk, // system clock
  input wire logic tx_valid, // value offered
  input wire logic [3:0] tx_offset, // offset of the value
  input wire logic [31:0] tx_data, // offered value
  input wire logic [3:0] stall, // extra reply delay in cycles
  input wire logic err_en, // make one offset fail
  input wire logic [3:0] err_off, // offset that fails
  output logic tx_ready, // take strobe
  output logic tx_ack, // reply pulse
  output logic tx_err, // reply carries an error
  output logic [15:0] tx_code // code with the reply
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ERR_CODE = 16'h00a5; // code of a failed take
  logic [3:0] seen_off [$]; // offsets taken, in order
  logic [31:0] seen_dat [$]; // values taken, in order
  int cnt = 0; // cycles left until the reply
  logic fail = 1'b0; // pending reply is an error
  initial begin
    tx_ready = 1'b0;
    tx_ack = 1'b0;
    tx_err = 1'b0;
    tx_code = 16'h0000;
  end
  // one value at a time; code lines toggle while no reply stands
  always @(negedge clk) begin
    tx_ready <= (cnt == 0) && tx_valid;
    tx_ack <= (cnt == 1);
    tx_err <= (cnt == 1) && fail;
    tx_code <= (cnt == 1) ? (fail ? ERR_CODE : 16'h0000) : ~tx_code;
    if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (tx_valid) begin
      seen_off.push_back(tx_offset);
      seen_dat.push_back(tx_data);
      fail <= err_en && (tx_offset == err_off);
      cnt <= int'(stall) + 2;
    end
  end
endmodule

// *** test/test_component_data_area_mapper.sv ***
// self-checking bench for the data area mapper
module test_component_data_area_mapper;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] WB = 16'h0040; // write area base
  localparam logic [15:0] RB = 16'h0080; // read area base
  logic clk = 1'b0, rst_n = 1'b0, wr_start = 1'b0;
  logic [15:0] wr_base = WB, rd_base = RB;
  mapper_pkg::comp_kind_t kind = mapper_pkg::comp_temp;
  logic [2:0] grp = 3'h1, rx_sel = 3'h0;
  logic busy, wr_done, dm_req, dm_we, dm_ack = 1'b0, armed = 1'b1;
  logic [15:0] dm_addr, dm_wdata, dm_rdata = 16'h0000, tx_code;
  logic tx_valid, tx_ready, tx_ack, tx_err, rx_ready;
  logic [3:0] tx_offset, stall = 4'h0, err_off = 4'h0;
  logic [31:0] tx_data, rx_value = 32'h0;
  logic err_en = 1'b0, rx_valid = 1'b0, rx_err = 1'b0;
  logic [15:0] rx_status = 16'h0, rx_code = 16'h00c3;
  logic [15:0] mem [0:255]; // data memory words
  int n_mismatch = 0, cmp_count = 0;
  int lo_tab [7] = '{1, 4, 7, 10, 12, 14, 16}; // low word per selector

  always #2.5 clk = ~clk;

  component_data_area_mapper i_component_data_area_mapper (.clk(clk),
    .rst_n(rst_n), .wr_start(wr_start), .wr_base(wr_base),
    .rd_base(rd_base), .kind(kind), .grp(grp), .busy(busy),
    .wr_done(wr_done), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_ack(dm_ack), .dm_rdata(dm_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_offset(tx_offset),
    .tx_data(tx_data), .tx_ack(tx_ack), .tx_err(tx_err), .tx_code(tx_code),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_sel(rx_sel),
    .rx_value(rx_value), .rx_status(rx_status), .rx_err(rx_err),
    .rx_code(rx_code));

  link_model i_link_model (.clk(clk), .tx_valid(tx_valid),
    .tx_offset(tx_offset), .tx_data(tx_data), .stall(stall),
    .err_en(err_en), .err_off(err_off), .tx_ready(tx_ready),
    .tx_ack(tx_ack), .tx_err(tx_err), .tx_code(tx_code));

  // memory: one ack per request, read data scrambled once released
  always @(negedge clk) begin
    if (dm_ack) begin
      dm_ack <= 1'b0;
      dm_rdata <= ~dm_rdata;
    end else if (dm_req && armed) begin
      dm_ack <= 1'b1;
      armed <= 1'b0;
      dm_rdata <= mem[dm_addr[7:0]];
      if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
    end
    if (!dm_req) armed <= 1'b1;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // words expected on the link per kind, group and operation code
  function automatic logic [9:0] exp_mask(logic k, logic [2:0] g,
                                          logic [15:0] op);
    logic [9:0] m;
    case ({k, g})
      4'h1: m = 10'h006;
      4'h2: m = 10'h01e;
      4'h3: m = 10'h0e6;
      4'h4: m = 10'h11a;
      4'h5: m = 10'h0fe;
      4'hb: m = 10'h002;
      4'hc: m = 10'h154;
      4'hd: m = 10'h156;
      default: m = 10'h000;
    endcase
    if (!k && op == 16'h0002 && m[2]) begin
      m = 10'h004;
    end else if (op == 16'h0000 || op > (k ? 16'h0004 : 16'h0005)) begin
      m[k ? 1 : 2] = 1'b0;
    end
    return m;
  endfunction

  // one write pass with its expected link traffic and monitor word
  task automatic write_pass(logic k, logic [2:0] g, logic [15:0] op,
                            logic ee, logic [3:0] eo);
    logic [9:0] m;
    logic [31:0] ev;
    int n, i;
    bit stop;
    n = 0;
    stop = 0;
    mem[WB + (k ? 16'h1 : 16'h2)] = op;
    mem[WB] = 16'h7777;
    i_link_model.seen_off.delete();
    i_link_model.seen_dat.delete();
    kind = mapper_pkg::comp_kind_t'(k);
    grp = g;
    err_en = ee;
    err_off = eo;
    stall = {1'b0, g};
    wr_start = 1'b1;
    @(negedge clk);
    wr_start = 1'b0;
    for (i = 0; i < 4000 && wr_done !== 1'b1; i++) @(negedge clk);
    if (i == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
    m = exp_mask(k, g, op);
    for (int o = 1; o <= 9; o++) begin
      if (m[o] && !stop) begin
        if (k && o >= 2) ev = {mem[WB + o + 1], mem[WB + o]};
        else ev = {{16{mem[WB + o][15]}}, mem[WB + o]};
        if (n < i_link_model.seen_off.size()) begin
          check("offset", 32'(i_link_model.seen_off[n]), o);
          check("value", i_link_model.seen_dat[n], ev);
        end
        n++;
        stop = ee && (o == eo);
      end
    end
    check("sent", i_link_model.seen_off.size(), n);
    check("monitor", mem[WB], ee ? 16'h00a5 : 16'h0000);
    $display("test write kind %0d group %0d op %h done", k, g, op);
  endtask

  // one meter value read, good or failed
  task automatic read_val(logic [2:0] s, logic e);
    int lo, i;
    bit took;
    lo = lo_tab[s];
    took = 0;
    for (i = 0; i < 18; i++) mem[RB + i] = 16'h5a5a;
    rx_valid = 1'b1;
    rx_sel = s;
    rx_err = e;
    rx_value = {16'hf000 + s, 16'h0100 + s};
    rx_status = 16'h0030 + s;
    for (i = 0; i < 100 && !took; i++) begin
      took = (rx_ready === 1'b1);
      @(negedge clk);
    end
    rx_valid = 1'b0;
    rx_value = ~rx_value;
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
    if (!took || i == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
    check("low", mem[RB + lo], e ? 16'h0 : 16'h0100 + s);
    check("high", mem[RB + lo + 1], e ? 16'h0 : 16'hf000 + s);
    if (s < 3)
      check("status", mem[RB + lo + 2], e ? 16'h0 : rx_status);
    check("rmon", mem[RB], e ? rx_code : 16'h0000);
    $display("test read sel %0d err %0d done", s, e);
  endtask

  // reset dropped while a value waits on the link; nothing more goes out
  task automatic reset_mid();
    int i;
    mem[WB + 16'h2] = 16'h0001;
    i_link_model.seen_off.delete();
    kind = mapper_pkg::comp_temp;
    grp = 3'h5;
    err_en = 1'b0;
    stall = 4'h3;
    wr_start = 1'b1;
    @(negedge clk);
    wr_start = 1'b0;
    for (i = 0; i < 200 && tx_valid !== 1'b1; i++) @(negedge clk);
    if (i == 200) begin
      n_mismatch++;
      tally_and_finish();
    end
    #1 rst_n = 1'b0;
    #1;
    check("reset busy", busy, 32'h0);
    check("reset valid", tx_valid, 32'h0);
    check("reset request", dm_req, 32'h0);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("reset sent", i_link_model.seen_off.size(), 1);
    $display("test reset in mid pass done");
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h8000 | 16'(i * 16'h0123);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    for (int g = 0; g <= 6; g++) write_pass(1'b0, g[2:0], 16'h0001, 0, 0);
    for (int op = 0; op <= 6; op++) write_pass(1'b0, 3'h1, 16'(op), 0, 0);
    write_pass(1'b0, 3'h5, 16'h0002, 0, 0);
    for (int g = 1; g <= 5; g++)
      write_pass(1'b1, g[2:0], 16'h0004, 0, 0);
    for (int op = 0; op <= 5; op++) write_pass(1'b1, 3'h5, 16'(op), 0, 0);
    reset_mid();
    write_pass(1'b1, 3'h4, 16'h0004, 1, 4'h4);
    write_pass(1'b0, 3'h2, 16'h0001, 1, 4'h1);
    write_pass(1'b0, 3'h5, 16'h0004, 1, 4'h3);
    for (int s = 0; s < 7; s++) read_val(s[2:0], 1'b0);
    read_val(3'h0, 1'b1);
    read_val(3'h5, 1'b1);
    tally_and_finish();
  end
endmodule
